// ==== rtl/uart_flow_pkg.sv ====
// register map, field layout and types of the uart flow-control block
// assumes an apb master with 32-bit data and byte addresses
package uart_flow_pkg;

  // --------------------
  // register byte addresses
  // --------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_FIFO_SETUP = 8'h04;
  localparam logic [7:0] ADDR_MODEM_LINE = 8'h08;
  localparam logic [7:0] ADDR_ENH_FEATURE = 8'h0c;
  localparam logic [7:0] ADDR_HALT_RESUME = 8'h10;
  localparam logic [7:0] ADDR_PROG_TRIGGER = 8'h14;
  localparam logic [7:0] ADDR_PIN_FUNCTION = 8'h18;
  localparam logic [7:0] ADDR_DIVISOR = 8'h1c;
  localparam logic [7:0] ADDR_GPIO = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  // --------------------
  // field positions
  // --------------------
  localparam int FIFO_EN_BIT = 0;
  localparam int RX_CLEAR_BIT = 1;
  localparam int TX_CLEAR_BIT = 2;
  localparam int DTR_BIT = 0;
  localparam int RTS_BIT = 1;
  localparam int AUTO_RTS_BIT = 6;
  localparam int AUTO_CTS_BIT = 7;
  localparam int MODEM_PINS_BIT = 1;
  localparam int GPIO_DIR_LSB = 8;
  localparam int RX_VALID_BIT = 31;

  // --------------------
  // reset values and level tables
  // --------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [3:0] BIT_TICKS_LAST = 4'hf;
  localparam logic [3:0] MID_BIT_TICK = 4'h7;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [3:0][6:0] RX_SEL_LEVELS =
    {7'h3c, 7'h38, 7'h10, 7'h08};
  localparam logic [3:0][6:0] RX_SEL_RESUME =
    {7'h38, 7'h10, 7'h08, 7'h00};
  localparam logic [3:0][6:0] TX_SEL_LEVELS =
    {7'h38, 7'h20, 7'h10, 7'h08};

  // --------------------
  // types
  // --------------------
  typedef enum logic [1:0] {
    SER_IDLE, SER_START, SER_DATA, SER_STOP
  } ser_state_type;

  typedef struct packed {
    logic brk;
    logic frame;
    logic parity;
    logic [7:0] data;
  } rx_entry_type;

  typedef struct packed {
    logic [3:0] pad_hi;
    logic [2:0] pins;
    logic tx_busy;
    logic ri;
    logic cd;
    logic cts_changed;
    logic overrun;
    logic cts_active;
    logic rts_n;
    logic tx_hit;
    logic rx_hit;
    logic pad_tx;
    logic [6:0] tx_count;
    logic pad_rx;
    logic [6:0] rx_count;
  } status_type;

endpackage

// ==== rtl/uart_flow_ctrl.sv ====
// uart core with fifo trigger levels and automatic rts/cts flow control
// assumes an apb master on pclk; serial pins are asynchronous to pclk
//
// Notes on behaviour
// - manual rts bit set to one drives rts_n low while automatic rts is off.
// - rts_n is high after any reset.
// - rts_n follows fifo fill only when automatic rts is enabled.
// - pin function bit 1 picks gpio or modem use of shared pins.
// - both fifos hold 64 characters; rx entries carry three error bits.
// - baud divisor ranges from 1 to 65535.
// - after reset fifos are off, so trigger levels are one character.
// - nonzero programmable trigger field overrides the selectable level.
// - automatic cts and rts enable independently by feature bits 7 and 6.
// - with automatic cts, each character starts only while cts active.
// - automatic rts deasserts when rx fill reaches the halt level.
// - after halt, rts reasserts once rx fill falls to resume level.
// - zero halt/resume register halts at the fifo setup rx trigger level and resumes one table step lower.
// - cts dropped before mid last stop bit holds back next character.
// - cts becoming active again resumes transmission from the fifo.
// - with automatic cts, cts changes raise no change flag.
// - with fifos on, one more character after rts deassertion is still accepted.
// - a character arriving at a full rx fifo flags overrun.
module uart_flow_ctrl #(
  parameter int DEPTH = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  input wire logic shared_pin_five_in,
  output logic shared_pin_five_out,
  output logic shared_pin_five_oe_n,
  input wire logic shared_pin_six_in,
  output logic shared_pin_six_out,
  output logic shared_pin_six_oe_n,
  input wire logic shared_pin_seven_in,
  output logic shared_pin_seven_out,
  output logic shared_pin_seven_oe_n
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  // status counts are seven bits wide
  if (DEPTH < 2 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two from 2 to 64");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // order: seven, six, five, cts_n, rxd
  logic [4:0] s1_reg, s2_reg, s3_reg, pin_reg;
  logic [4:0] pin_next;
  wire [4:0] pin_raw = {shared_pin_seven_in, shared_pin_six_in,
                        shared_pin_five_in, cts_n, rxd};
  // a change is taken only when stages two and three agree
  assign pin_next = (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 5'h1f;
      s2_reg <= 5'h1f;
      s3_reg <= 5'h1f;
      pin_reg <= 5'h1f;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  wire rxd_f = pin_reg[0];
  wire cts_n_f = pin_reg[1];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [7:0] fifo_setup_settings_reg;
  logic [7:0] modem_line_settings_reg;
  logic [7:0] enhanced_feature_settings_reg;
  logic [7:0] halt_resume_levels_reg;
  logic [7:0] programmable_trigger_levels_reg;
  logic [7:0] pin_function_select_reg;
  logic [15:0] divisor_reg;
  logic [10:0] gpio_reg;
  logic [31:0] prdata_reg;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_data = paddr == uart_flow_pkg::ADDR_DATA;
  wire hit_fcr = paddr == uart_flow_pkg::ADDR_FIFO_SETUP;
  wire hit_mcr = paddr == uart_flow_pkg::ADDR_MODEM_LINE;
  wire hit_efr = paddr == uart_flow_pkg::ADDR_ENH_FEATURE;
  wire hit_tcr = paddr == uart_flow_pkg::ADDR_HALT_RESUME;
  wire hit_tlr = paddr == uart_flow_pkg::ADDR_PROG_TRIGGER;
  wire hit_pfs = paddr == uart_flow_pkg::ADDR_PIN_FUNCTION;
  wire hit_div = paddr == uart_flow_pkg::ADDR_DIVISOR;
  wire hit_gpio = paddr == uart_flow_pkg::ADDR_GPIO;
  wire hit_stat = paddr == uart_flow_pkg::ADDR_STATUS;
  wire mapped = hit_data | hit_fcr | hit_mcr | hit_efr | hit_tcr |
                hit_tlr | hit_pfs | hit_div | hit_gpio | hit_stat;
  wire wr = access & pwrite & mapped;
  wire rd = access & ~pwrite & mapped;

  wire fifo_en = fifo_setup_settings_reg[uart_flow_pkg::FIFO_EN_BIT];
  wire auto_rts =
    enhanced_feature_settings_reg[uart_flow_pkg::AUTO_RTS_BIT];
  wire auto_cts =
    enhanced_feature_settings_reg[uart_flow_pkg::AUTO_CTS_BIT];
  wire modem_pins =
    pin_function_select_reg[uart_flow_pkg::MODEM_PINS_BIT];

  // any change of the enable bit empties both fifos
  wire fcr_wr = wr & hit_fcr;
  wire en_flip = fcr_wr & (pwdata[uart_flow_pkg::FIFO_EN_BIT] != fifo_en);
  wire rx_flush =
    en_flip | (fcr_wr & pwdata[uart_flow_pkg::RX_CLEAR_BIT]);
  wire tx_flush =
    en_flip | (fcr_wr & pwdata[uart_flow_pkg::TX_CLEAR_BIT]);

  // ----------------------------------------------------------------
  // fifo bookkeeping
  // ----------------------------------------------------------------
  // fifo off leaves a single holding slot
  wire [CW-1:0] cap = fifo_en ? CW'(DEPTH) : CW'(1);
  logic [7:0] tx_mem [DEPTH];
  uart_flow_pkg::rx_entry_type rx_mem [DEPTH];
  logic [PW-1:0] tx_wr_reg, tx_rd_reg, rx_wr_reg, rx_rd_reg;
  logic [CW-1:0] tx_count_reg, rx_count_reg;
  logic tx_push, tx_pop, rx_push, rx_pop;
  uart_flow_pkg::rx_entry_type rx_entry;

  wire tx_full = tx_count_reg >= cap;
  wire rx_full = rx_count_reg >= cap;
  assign tx_push = wr & hit_data & ~tx_full;
  wire rx_valid = rx_count_reg != '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_count_reg <= '0;
    end else if (tx_flush) begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_count_reg <= '0;
    end else begin
      tx_wr_reg <= tx_wr_reg + PW'(tx_push);
      tx_rd_reg <= tx_rd_reg + PW'(tx_pop);
      tx_count_reg <= tx_count_reg + CW'(tx_push) - CW'(tx_pop);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_count_reg <= '0;
    end else if (rx_flush) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_count_reg <= '0;
    end else begin
      rx_wr_reg <= rx_wr_reg + PW'(rx_push);
      rx_rd_reg <= rx_rd_reg + PW'(rx_pop);
      rx_count_reg <= rx_count_reg + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // storage needs no reset; pointers guard every read
  always_ff @(posedge pclk) begin
    if (tx_push)
      tx_mem[tx_wr_reg] <= pwdata[7:0];
    if (rx_push)
      rx_mem[rx_wr_reg] <= rx_entry;
  end

  // ----------------------------------------------------------------
  // trigger and flow levels
  // ----------------------------------------------------------------
  wire [3:0] tlr_rx = programmable_trigger_levels_reg[7:4];
  wire [3:0] tlr_tx = programmable_trigger_levels_reg[3:0];
  wire [1:0] rx_sel = fifo_setup_settings_reg[7:6];
  wire [1:0] tx_sel = fifo_setup_settings_reg[5:4];
  wire [6:0] rx_lvl = (tlr_rx != 4'h0) ? {1'b0, tlr_rx, 2'b00}
                      : uart_flow_pkg::RX_SEL_LEVELS[rx_sel];
  wire [6:0] tx_lvl = (tlr_tx != 4'h0) ? {1'b0, tlr_tx, 2'b00}
                      : uart_flow_pkg::TX_SEL_LEVELS[tx_sel];
  wire [6:0] rx_eff = fifo_en ? rx_lvl : 7'h01;
  wire [6:0] tx_eff = fifo_en ? tx_lvl : 7'h01;
  wire [6:0] rx_cnt7 = 7'(rx_count_reg);
  wire [6:0] tx_space = 7'(cap - tx_count_reg);
  wire rx_hit = rx_cnt7 >= rx_eff;
  wire tx_hit = tx_space >= tx_eff;

  wire tcr_zero = halt_resume_levels_reg == 8'h00;
  wire [6:0] halt_sel = tcr_zero ? uart_flow_pkg::RX_SEL_LEVELS[rx_sel]
    : {1'b0, halt_resume_levels_reg[3:0], 2'b00};
  wire [6:0] resume_sel = tcr_zero ? uart_flow_pkg::RX_SEL_RESUME[rx_sel]
    : {1'b0, halt_resume_levels_reg[7:4], 2'b00};
  wire [6:0] halt_lvl = fifo_en ? halt_sel : 7'h01;
  wire [6:0] resume_lvl = fifo_en ? resume_sel : 7'h00;

  // ----------------------------------------------------------------
  // rts and cts
  // ----------------------------------------------------------------
  logic halted_reg, rts_n_reg, cts_chg_reg, overrun_reg;
  logic halted_next, clr_cts_chg, clr_overrun;

  // hysteresis: stays halted until the fill falls to resume
  assign halted_next = halted_reg ? (rx_cnt7 > resume_lvl)
                                  : (rx_cnt7 >= halt_lvl);
  wire cts_chg_set = ~auto_cts & (pin_next[1] ^ cts_n_f);
  wire overrun_set; // set by the receiver below

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_reg <= 1'b0;
      rts_n_reg <= 1'b1;
      cts_chg_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      halted_reg <= halted_next;
      // manual bit only steers the pin with auto rts off
      rts_n_reg <= auto_rts ? halted_reg
        : ~modem_line_settings_reg[uart_flow_pkg::RTS_BIT];
      // a new event beats a read-clear in the same cycle
      cts_chg_reg <= cts_chg_set | (cts_chg_reg & ~clr_cts_chg);
      overrun_reg <= overrun_set | (overrun_reg & ~clr_overrun);
    end
  end

  // ----------------------------------------------------------------
  // baud tick, sixteen per bit
  // ----------------------------------------------------------------
  logic [15:0] baud_cnt_reg;
  // divisor zero stops the generator
  wire tick = (divisor_reg != 16'h0000) &&
              (baud_cnt_reg >= divisor_reg - 16'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      baud_cnt_reg <= 16'h0000;
    else
      baud_cnt_reg <= tick ? 16'h0000 : baud_cnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  uart_flow_pkg::ser_state_type tx_state_reg;
  logic [3:0] tx_tick_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic txd_reg;

  // cts is looked at only between characters
  wire cts_ok = ~auto_cts | ~cts_n_f;
  wire tx_idle = tx_state_reg == uart_flow_pkg::SER_IDLE;
  assign tx_pop = tx_idle & (tx_count_reg != '0) & cts_ok;
  wire tx_end = tick & (tx_tick_reg == uart_flow_pkg::BIT_TICKS_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= uart_flow_pkg::SER_IDLE;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      txd_reg <= 1'b1;
    end else begin
      if (tick)
        tx_tick_reg <= tx_tick_reg + 4'h1;
      case (tx_state_reg)
        uart_flow_pkg::SER_IDLE: begin
          tx_tick_reg <= 4'h0;
          if (tx_pop) begin
            tx_shift_reg <= tx_mem[tx_rd_reg];
            txd_reg <= 1'b0;
            tx_state_reg <= uart_flow_pkg::SER_START;
          end
        end
        uart_flow_pkg::SER_START: begin
          if (tx_end) begin
            txd_reg <= tx_shift_reg[0];
            tx_bit_reg <= 3'h0;
            tx_state_reg <= uart_flow_pkg::SER_DATA;
          end
        end
        uart_flow_pkg::SER_DATA: begin
          if (tx_end) begin
            if (tx_bit_reg == uart_flow_pkg::LAST_DATA_BIT) begin
              txd_reg <= 1'b1;
              tx_state_reg <= uart_flow_pkg::SER_STOP;
            end else begin
              tx_bit_reg <= tx_bit_reg + 3'h1;
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              txd_reg <= tx_shift_reg[1];
            end
          end
        end
        uart_flow_pkg::SER_STOP: begin
          // current character always completes
          if (tx_end)
            tx_state_reg <= uart_flow_pkg::SER_IDLE;
        end
        default: tx_state_reg <= uart_flow_pkg::SER_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  uart_flow_pkg::ser_state_type rx_state_reg;
  logic [3:0] rx_tick_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;

  wire rx_end = tick & (rx_tick_reg == uart_flow_pkg::BIT_TICKS_LAST);
  wire rx_done = (rx_state_reg == uart_flow_pkg::SER_STOP) & rx_end;
  assign rx_entry.brk = (rx_shift_reg == 8'h00) & ~rxd_f;
  assign rx_entry.frame = ~rxd_f;
  assign rx_entry.parity = 1'b0;
  assign rx_entry.data = rx_shift_reg;
  // accepted whatever rts shows, while room remains
  assign rx_push = rx_done & ~rx_full;
  assign overrun_set = rx_done & rx_full;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= uart_flow_pkg::SER_IDLE;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
    end else begin
      if (tick)
        rx_tick_reg <= rx_tick_reg + 4'h1;
      case (rx_state_reg)
        uart_flow_pkg::SER_IDLE: begin
          rx_tick_reg <= 4'h0;
          if (!rxd_f)
            rx_state_reg <= uart_flow_pkg::SER_START;
        end
        uart_flow_pkg::SER_START: begin
          // a glitch shorter than half a bit is dropped
          if (tick && rx_tick_reg == uart_flow_pkg::MID_BIT_TICK) begin
            rx_tick_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_state_reg <= rxd_f ? uart_flow_pkg::SER_IDLE
                                  : uart_flow_pkg::SER_DATA;
          end
        end
        uart_flow_pkg::SER_DATA: begin
          if (rx_end) begin
            rx_shift_reg <= {rxd_f, rx_shift_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == uart_flow_pkg::LAST_DATA_BIT)
              rx_state_reg <= uart_flow_pkg::SER_STOP;
          end
        end
        uart_flow_pkg::SER_STOP: begin
          if (rx_end)
            rx_state_reg <= uart_flow_pkg::SER_IDLE;
        end
        default: rx_state_reg <= uart_flow_pkg::SER_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shared modem pins
  // ----------------------------------------------------------------
  // modem use: five drives dtr, six and seven are cd and ri inputs
  wire [2:0] gpio_out = gpio_reg[2:0];
  wire [2:0] gpio_dir = gpio_reg[10:8];
  assign shared_pin_five_out = modem_pins
    ? ~modem_line_settings_reg[uart_flow_pkg::DTR_BIT] : gpio_out[0];
  assign shared_pin_five_oe_n = modem_pins ? 1'b0 : ~gpio_dir[0];
  assign shared_pin_six_out = gpio_out[1];
  assign shared_pin_six_oe_n = modem_pins | ~gpio_dir[1];
  assign shared_pin_seven_out = gpio_out[2];
  assign shared_pin_seven_oe_n = modem_pins | ~gpio_dir[2];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  uart_flow_pkg::status_type status, cap_stat;
  assign status.pad_hi = 4'h0;
  assign status.pins = pin_reg[4:2];
  assign status.tx_busy = ~tx_idle;
  assign status.ri = modem_pins & ~pin_reg[4];
  assign status.cd = modem_pins & ~pin_reg[3];
  assign status.cts_changed = cts_chg_reg;
  assign status.overrun = overrun_reg;
  assign status.cts_active = ~cts_n_f;
  assign status.rts_n = rts_n_reg;
  assign status.tx_hit = tx_hit;
  assign status.rx_hit = rx_hit;
  assign status.pad_tx = 1'b0;
  assign status.tx_count = 7'(tx_count_reg);
  assign status.pad_rx = 1'b0;
  assign status.rx_count = rx_cnt7;

  wire [31:0] rd_mux =
    hit_data ? {rx_valid, 20'h0, rx_mem[rx_rd_reg]} :
    hit_fcr ? {24'h0, fifo_setup_settings_reg} :
    hit_mcr ? {24'h0, modem_line_settings_reg} :
    hit_efr ? {24'h0, enhanced_feature_settings_reg} :
    hit_tcr ? {24'h0, halt_resume_levels_reg} :
    hit_tlr ? {24'h0, programmable_trigger_levels_reg} :
    hit_pfs ? {24'h0, pin_function_select_reg} :
    hit_div ? {16'h0, divisor_reg} :
    hit_gpio ? {21'h0, gpio_reg} :
    hit_stat ? status : 32'h0;

  // reads act only on what the setup phase captured
  assign cap_stat = prdata_reg;
  assign rx_pop = rd & hit_data & prdata_reg[uart_flow_pkg::RX_VALID_BIT];
  assign clr_overrun = rd & hit_stat & cap_stat.overrun;
  assign clr_cts_chg = rd & hit_stat & cap_stat.cts_changed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_setup_settings_reg <= uart_flow_pkg::CTRL_RESET;
      modem_line_settings_reg <= uart_flow_pkg::CTRL_RESET;
      enhanced_feature_settings_reg <= uart_flow_pkg::CTRL_RESET;
      halt_resume_levels_reg <= uart_flow_pkg::CTRL_RESET;
      programmable_trigger_levels_reg <= uart_flow_pkg::CTRL_RESET;
      pin_function_select_reg <= uart_flow_pkg::CTRL_RESET;
      divisor_reg <= uart_flow_pkg::DIVISOR_RESET;
      gpio_reg <= 11'h000;
      prdata_reg <= 32'h0;
    end else begin
      if (setup && !pwrite)
        prdata_reg <= rd_mux;
      if (fcr_wr)
        fifo_setup_settings_reg <= {pwdata[7:3], 2'b00, pwdata[0]};
      if (wr && hit_mcr)
        modem_line_settings_reg <= pwdata[7:0];
      if (wr && hit_efr)
        enhanced_feature_settings_reg <= pwdata[7:0];
      if (wr && hit_tcr)
        halt_resume_levels_reg <= pwdata[7:0];
      if (wr && hit_tlr)
        programmable_trigger_levels_reg <= pwdata[7:0];
      if (wr && hit_pfs)
        pin_function_select_reg <= pwdata[7:0];
      if (wr && hit_div)
        divisor_reg <= pwdata[15:0];
      if (wr && hit_gpio)
        gpio_reg <= {pwdata[10:8], 5'h00, pwdata[2:0]};
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access & (~mapped | (pwrite & hit_data & tx_full));
  assign txd = txd_reg;
  assign rts_n = rts_n_reg;

endmodule

// ==== testbench/uart_flow_ctrl_assertions.sv ====
// port-level checker for the uart flow-control block
// assumes it is bound to uart_flow_ctrl and sees only its ports
module uart_flow_ctrl_checker #(
  parameter int DEPTH = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rts_n,
  input wire logic shared_pin_five_out,
  input wire logic shared_pin_five_oe_n,
  input wire logic shared_pin_six_oe_n,
  input wire logic shared_pin_seven_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // register mirrors
  // --------------------
  logic a_rts_reg, man_reg, dtr_reg, pf_reg;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire pins_in = shared_pin_six_oe_n && shared_pin_seven_oe_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {a_rts_reg, man_reg, dtr_reg, pf_reg} <= 4'h0;
    end else begin
      if (wr && paddr == uart_flow_pkg::ADDR_ENH_FEATURE) begin
        a_rts_reg <= pwdata[6];
      end
      if (wr && paddr == uart_flow_pkg::ADDR_MODEM_LINE) begin
        {man_reg, dtr_reg} <= pwdata[1:0];
      end
      if (wr && paddr == uart_flow_pkg::ADDR_PIN_FUNCTION) begin
        pf_reg <= pwdata[1];
      end
    end
  end
  // --------------------
  // properties
  // --------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // rts register may lag the control write by two cycles
  sequence s_man_on; (!a_rts_reg && man_reg) [*3]; endsequence
  sequence s_man_off; (!a_rts_reg && !man_reg) [*3]; endsequence
  sequence s_modem; pf_reg [*3]; endsequence
  AST_RTS_RESET: assert property ($rose(presetn) |-> rts_n [*2])
    else $error("rts_n not high after reset");
  AST_MANUAL_ON: assert property (s_man_on |-> !rts_n)
    else $error("manual rts set but rts_n high");
  AST_MANUAL_OFF: assert property (s_man_off |-> rts_n)
    else $error("manual rts clear but rts_n low");
  AST_MODEM_DIR: assert property (
    s_modem |-> !shared_pin_five_oe_n && pins_in)
    else $error("modem pin directions wrong");
  AST_DTR_PIN: assert property (
    s_modem and (dtr_reg [*3]) |-> !shared_pin_five_out)
    else $error("pin five not driven from dtr");
  AST_PINS_RESET: assert property (
    $rose(presetn) |-> shared_pin_five_oe_n && pins_in)
    else $error("pins driven after reset");
  AST_BAD_ADDR: assert property (access && paddr > 8'h24 |->
    pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_ZERO_WAIT: assert property (access |-> pready)
    else $error("apb wait state inserted");
endmodule
bind uart_flow_ctrl uart_flow_ctrl_checker #(.DEPTH(DEPTH)) i_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .rts_n, .shared_pin_five_out, .shared_pin_five_oe_n,
  .shared_pin_six_oe_n, .shared_pin_seven_oe_n);

// ==== testbench/remote_uart.sv ====
// remote uart model on the serial side, 8n1 at 16 pclk per bit
// assumes the device divisor is 1
module remote_uart (
  input wire logic pclk,
  input wire logic rts_n,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  // ignore_rts lets a scenario overrun a receiver on purpose
  task automatic send(input logic [7:0] c, input bit ignore_rts);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    @(posedge pclk);
    while (rts_n && !ignore_rts) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge pclk);
    end
  endtask
  task automatic get(output logic [7:0] c);
    while (txd) @(posedge pclk);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge pclk);
      c[i] = txd;
    end
    repeat (16) @(posedge pclk);
  endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the uart flow-control block
// assumes divisor 1 and the remote model on the serial line
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, cts_n, held;
  logic [7:0] paddr, c;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, txd, rts_n, rxd, e, p5, p6, p7;
  int n_fail, total_checks;
  uart_flow_ctrl i_uart_flow_ctrl (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd,
    .cts_n, .rts_n, .shared_pin_five_in(1'b1), .shared_pin_five_out(p5),
    .shared_pin_five_oe_n(), .shared_pin_six_in(1'b1),
    .shared_pin_six_out(p6), .shared_pin_six_oe_n(),
    .shared_pin_seven_in(1'b1), .shared_pin_seven_out(p7),
    .shared_pin_seven_oe_n());
  remote_uart i_remote_uart (.pclk, .rts_n, .txd, .rxd);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // --------------------
  // tasks
  // --------------------
  task automatic chk(input string n, input logic [31:0] x, s);
    total_checks++;
    if (s !== x) begin
      $display("ERROR %s expected %h seen %h", n, x, s);
      n_fail++;
    end
  endtask
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    report_and_stop;
  end
  // --------------------
  // scenarios
  // --------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cts_n} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk("rts_n reset", 32'h1, rts_n);
    apb(1'b0, uart_flow_pkg::ADDR_DIVISOR, 32'h0);
    chk("divisor", 32'h1, r);
    apb(1'b1, uart_flow_pkg::ADDR_DIVISOR, 32'hffff);
    apb(1'b0, uart_flow_pkg::ADDR_DIVISOR, 32'h0);
    chk("divisor max", 32'hffff, r);
    apb(1'b1, uart_flow_pkg::ADDR_DIVISOR, 32'h1);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped", 32'h1, e);
    apb(1'b1, uart_flow_pkg::ADDR_MODEM_LINE, 32'h2);
    repeat (3) @(posedge pclk);
    chk("rts manual on", 32'h0, rts_n);
    apb(1'b1, uart_flow_pkg::ADDR_MODEM_LINE, 32'h0);
    repeat (3) @(posedge pclk);
    chk("rts manual off", 32'h1, rts_n);
    i_remote_uart.send(8'h3c, 1'b1);
    i_remote_uart.send(8'h3c, 1'b1);
    apb(1'b0, uart_flow_pkg::ADDR_STATUS, 32'h0);
    chk("overrun", 32'h1, r[20]);
    apb(1'b0, uart_flow_pkg::ADDR_DATA, 32'h0);
    chk("rx entry", 32'h8000003c, r);
    apb(1'b1, uart_flow_pkg::ADDR_ENH_FEATURE, 32'h40);
    repeat (3) @(posedge pclk);
    chk("rts auto", 32'h0, rts_n);
    i_remote_uart.send(8'ha5, 1'b0);
    repeat (4) @(posedge pclk);
    chk("rts halt", 32'h1, rts_n);
    apb(1'b0, uart_flow_pkg::ADDR_DATA, 32'h0);
    chk("rx char", 32'h800000a5, r);
    repeat (4) @(posedge pclk);
    chk("rts resume", 32'h0, rts_n);
    apb(1'b1, uart_flow_pkg::ADDR_FIFO_SETUP, 32'h1);
    i_remote_uart.send(8'h5a, 1'b0);
    chk("rts below halt", 32'h0, rts_n);
    apb(1'b1, uart_flow_pkg::ADDR_ENH_FEATURE, 32'h80);
    apb(1'b1, uart_flow_pkg::ADDR_DATA, 32'h11);
    apb(1'b1, uart_flow_pkg::ADDR_DATA, 32'h22);
    fork
      i_remote_uart.get(c);
      begin
        repeat (60) @(posedge pclk);
        cts_n <= 1'b1;
      end
    join
    chk("tx first", 32'h11, c);
    held = 1'b1;
    repeat (200) begin
      @(posedge pclk);
      held = held & txd;
    end
    chk("tx held", 32'h1, held);
    cts_n <= 1'b0;
    i_remote_uart.get(c);
    chk("tx resume", 32'h22, c);
    apb(1'b0, uart_flow_pkg::ADDR_STATUS, 32'h0);
    chk("cts flag", 32'h0, r[21]);
    apb(1'b1, uart_flow_pkg::ADDR_GPIO, 32'h6);
    apb(1'b1, uart_flow_pkg::ADDR_PIN_FUNCTION, 32'h2);
    apb(1'b1, uart_flow_pkg::ADDR_MODEM_LINE, 32'h1);
    repeat (2) @(posedge pclk);
    chk("dtr pin", 32'h0, p5);
    chk("gpio out", 32'h3, {p7, p6});
    report_and_stop;
  end
endmodule
